// >>> logic/monitor_pkg.sv
// constants and types shared by the shunt monitor configuration block
// Operation
// - Writing one to bit 15 of the configuration word resets every register to its default, and the bit clears itself.
// - Bits 14, 13 and 12 enable channels one, two and three, one meaning enabled, all enabled by default.
// - Bits 11 to 9 pick 1, 4, 16, 64, 128, 256, 512 or 1024 averaged samples, default 1.
// - Bits 8 to 6 pick a bus conversion time from 140 us up to 8.244 ms, default code 100.
// - Bits 5 to 3 pick the shunt conversion time with the same table, default code 100.
// - Bits 2 to 0 pick power-down (000, 100), single-shot (001 to 011) or continuous (101 to 111) shunt, bus or both.
// - Reading the configuration word never disturbs the settings or a running conversion.
// - Writing the configuration word halts conversion until the write ends, then a new one starts with the new settings.
// - After reset the configuration word reads 7127h.
// - The channel-1 shunt result is twos complement with sign in bit 15, data in 14 to 3 and zeros in 2 to 0.
// - One result step is 40 uV and positive full scale of 163.8 mV reads 7FF8.
// - The channel-1 shunt result holds the average over the selected number of samples.
// - Every 16-bit register moves over the two-wire link as two bytes, high byte first.
package monitor_pkg;

  localparam logic [7:0]  CFG_OFFSET    = 8'h00;
  localparam logic [7:0]  RESULT_OFFSET = 8'h01;
  localparam logic [15:0] CFG_RESET     = 16'h7127;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam int          SOFT_RESET_BIT = 15;
  localparam int          RESULT_LSB     = 3;
  localparam int          SAMPLE_WIDTH   = 13;
  localparam logic [6:0]  DEV_ADDR_DEF   = 7'h40;

  // averaging codes as shift amounts: 1,4,16,64,128,256,512,1024
  localparam logic [3:0] AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000,
                                               1100000, 2116000, 4156000, 8244000};
  localparam int unsigned CONV_CYCLES_DEF [8] = '{
    CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
    CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
    CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
    CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};

  typedef struct packed {
    logic       softReset;
    logic       chan_one_enable;
    logic       chan_two_enable;
    logic       chan_three_enable;
    logic [2:0] sample_average_count;
    logic [2:0] bus_conversion_time;
    logic [2:0] shunt_conversion_time;
    logic [2:0] operating_mode_select;
  } measurement_config_s;

  typedef enum logic [3:0] {
    LINK_IDLE, LINK_ADDR, LINK_ACK_ADDR, LINK_PTR, LINK_ACK_PTR,
    LINK_WRITE, LINK_ACK_WRITE, LINK_READ, LINK_ACK_READ
  } link_state_e;

  typedef enum logic {ENG_IDLE, ENG_CONV} engine_state_e;

endpackage

// >>> logic/shunt_monitor.sv
// configuration register, conversion sequencer and channel-1 shunt result behind a two-wire slave
`timescale 1ns/100ps
`default_nettype none
module shunt_monitor
#(
  parameter logic [6:0]  DEV_ADDR         = monitor_pkg::DEV_ADDR_DEF,
  parameter int unsigned CONV_CYCLES [8]  = monitor_pkg::CONV_CYCLES_DEF
)
(
  // clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  rstn,
  // two-wire link
  input  wire logic                                  scl,
  input  wire logic                                  sdaIn,
  output var  logic                                  sdaOut,
  output var  logic                                  sdaOe,
  // converter front end
  input  wire logic signed [monitor_pkg::SAMPLE_WIDTH-1:0] shuntSample,
  output var  logic                                  convActive,
  output var  logic [1:0]                            muxChannel,
  output var  logic                                  muxBus
);
  import monitor_pkg::*;

  // link synchronisers and edge history
  logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
  logic sclRise, sclFall, startCond, stopCond;

  // link state
  link_state_e linkState_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bitCnt_reg;
  logic        isRead_reg, byteHigh_reg, ackOn_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  wrHigh_reg;
  logic        writeHold_reg;
  logic        cfgWrite_reg;
  logic [15:0] cfgWord_reg;
  logic        sdaOe_reg;
  logic [15:0] readWord;
  logic [7:0]  rxByte;

  // configuration and result
  measurement_config_s cfg_reg;
  logic                softRst_reg;
  logic [15:0]         result_reg;
  logic                localRst;

  // conversion engine
  engine_state_e engState_reg;
  logic [2:0]    step_reg;
  logic [17:0]   timer_reg;
  logic [10:0]   avgCnt_reg;
  logic signed [23:0] acc_reg;
  logic          startPending_reg;
  logic [5:0]    stepEnabled;
  logic [2:0]    firstStep, nextStep;
  logic          anyStep, hasNext;
  logic signed [23:0] accSum, avgValue;
  logic [10:0]   avgTarget;
  logic [2:0]    chanOn;

  assign localRst = !rstn || softRst_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end
    else
    begin
      sclMeta <= scl;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  assign sclRise   = sclSync && !sclPrev;
  assign sclFall   = !sclSync && sclPrev;
  assign startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign stopCond  = sclSync && sclPrev && !sdaPrev && sdaSync;
  assign rxByte    = {shift_reg[6:0], sdaSync};

  // reads only select a word; nothing here changes state
  always_comb
  begin
    case (ptr_reg)
      CFG_OFFSET:    readWord = {1'b0, cfg_reg[14:0]};
      RESULT_OFFSET: readWord = result_reg;
      default:       readWord = 16'h0000;
    endcase
  end

  // two-wire slave; a register is two bytes, high first
  always_ff @(posedge core_clk)
  begin
    cfgWrite_reg <= 1'b0;
    if (!rstn)
    begin
      linkState_reg <= LINK_IDLE;
      shift_reg     <= 8'h00;
      bitCnt_reg    <= 3'h0;
      isRead_reg    <= 1'b0;
      byteHigh_reg  <= 1'b1;
      ackOn_reg     <= 1'b0;
      ptr_reg       <= CFG_OFFSET;
      wrHigh_reg    <= 8'h00;
      writeHold_reg <= 1'b0;
      cfgWord_reg   <= CFG_RESET;
      sdaOe_reg     <= 1'b0;
    end
    else if (startCond || stopCond)
    begin
      linkState_reg <= startCond ? LINK_ADDR : LINK_IDLE;
      bitCnt_reg    <= 3'h0;
      ackOn_reg     <= 1'b0;
      sdaOe_reg     <= 1'b0;
      writeHold_reg <= 1'b0;
    end
    else
    begin
      case (linkState_reg)
        LINK_ADDR, LINK_PTR, LINK_WRITE:
        begin
          if (sclRise)
          begin
            shift_reg  <= rxByte;
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (bitCnt_reg == 3'h7)
            begin
              case (linkState_reg)
                LINK_ADDR:
                begin
                  isRead_reg    <= sdaSync;
                  byteHigh_reg  <= 1'b1;
                  linkState_reg <= (shift_reg[6:0] == DEV_ADDR) ? LINK_ACK_ADDR : LINK_IDLE;
                end
                LINK_PTR:
                begin
                  ptr_reg       <= rxByte;
                  byteHigh_reg  <= 1'b1;
                  linkState_reg <= LINK_ACK_PTR;
                end
                default:
                begin
                  if (byteHigh_reg)
                    wrHigh_reg <= rxByte;
                  else if (ptr_reg == CFG_OFFSET)
                  begin
                    cfgWrite_reg <= 1'b1;
                    cfgWord_reg  <= {wrHigh_reg, rxByte};
                  end
                  byteHigh_reg  <= !byteHigh_reg;
                  linkState_reg <= LINK_ACK_WRITE;
                end
              endcase
            end
          end
          // a rise here may still turn into a repeated start, so the hold waits for a fall
          else if (sclFall && linkState_reg == LINK_WRITE && ptr_reg == CFG_OFFSET && bitCnt_reg != 3'h0)
            writeHold_reg <= 1'b1;
        end
        LINK_ACK_ADDR, LINK_ACK_PTR, LINK_ACK_WRITE:
        begin
          if (sclFall)
          begin
            if (!ackOn_reg)
            begin
              ackOn_reg <= 1'b1;
              sdaOe_reg <= 1'b1;
            end
            else
            begin
              ackOn_reg  <= 1'b0;
              bitCnt_reg <= 3'h0;
              if (linkState_reg == LINK_ACK_ADDR && isRead_reg)
              begin
                shift_reg     <= readWord[15:8];
                sdaOe_reg     <= !readWord[15];
                byteHigh_reg  <= 1'b0;
                linkState_reg <= LINK_READ;
              end
              else
              begin
                sdaOe_reg     <= 1'b0;
                linkState_reg <= (linkState_reg == LINK_ACK_ADDR) ? LINK_PTR : LINK_WRITE;
              end
            end
          end
        end
        LINK_READ:
        begin
          if (sclFall)
          begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
            if (bitCnt_reg == 3'h7)
            begin
              sdaOe_reg     <= 1'b0;
              linkState_reg <= LINK_ACK_READ;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sdaOe_reg <= !shift_reg[6];
            end
          end
        end
        LINK_ACK_READ:
        begin
          if (sclRise && sdaSync)
            linkState_reg <= LINK_IDLE;
          else if (sclFall)
          begin
            shift_reg     <= byteHigh_reg ? readWord[15:8] : readWord[7:0];
            sdaOe_reg     <= byteHigh_reg ? !readWord[15] : !readWord[7];
            byteHigh_reg  <= !byteHigh_reg;
            bitCnt_reg    <= 3'h0;
            linkState_reg <= LINK_READ;
          end
        end
        default:
          linkState_reg <= LINK_IDLE;
      endcase
    end
  end

  // soft reset is a one-cycle pulse; bit 15 is never stored and reads back as zero
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      softRst_reg <= 1'b0;
    else
      softRst_reg <= cfgWrite_reg && cfgWord_reg[SOFT_RESET_BIT];
  end

  always_ff @(posedge core_clk)
  begin
    if (localRst)
      cfg_reg <= measurement_config_s'(CFG_RESET);
    else if (cfgWrite_reg && !cfgWord_reg[SOFT_RESET_BIT])
      cfg_reg <= measurement_config_s'({1'b0, cfgWord_reg[14:0]});
  end

  // step = channel*2 + phase; phase 1 is the bus conversion
  assign chanOn = {cfg_reg.chan_three_enable, cfg_reg.chan_two_enable, cfg_reg.chan_one_enable};
  generate
    for (genvar s = 0; s < 6; s++)
    begin : gStep
      assign stepEnabled[s] = chanOn[s/2] && cfg_reg.operating_mode_select[s%2];
    end
  endgenerate

  always_comb
  begin
    firstStep = 3'h0;
    anyStep   = 1'b0;
    nextStep  = 3'h0;
    hasNext   = 1'b0;
    for (int s = 5; s >= 0; s--)
    begin
      if (stepEnabled[s])
      begin
        firstStep = 3'(s);
        anyStep   = 1'b1;
        if (3'(s) > step_reg)
        begin
          nextStep = 3'(s);
          hasNext  = 1'b1;
        end
      end
    end
  end

  // sum is wide enough for 1024 full-scale samples without wrapping
  assign accSum    = acc_reg + ((step_reg == 3'h0) ? 24'(shuntSample) : 24'sh000000);
  assign avgValue  = accSum >>> AVG_SHIFT[cfg_reg.sample_average_count];
  assign avgTarget = 11'h001 << AVG_SHIFT[cfg_reg.sample_average_count];

  function automatic logic [17:0] loadTime(input logic [2:0] stepIdx, input measurement_config_s c);
    loadTime = stepIdx[0] ? 18'(CONV_CYCLES[c.bus_conversion_time])
                          : 18'(CONV_CYCLES[c.shunt_conversion_time]);
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (localRst)
    begin
      engState_reg     <= ENG_IDLE;
      step_reg         <= 3'h0;
      timer_reg        <= 18'h00000;
      avgCnt_reg       <= 11'h000;
      acc_reg          <= 24'sh000000;
      startPending_reg <= 1'b1;
      result_reg       <= RESULT_RESET;
    end
    else if (writeHold_reg)
    begin
      // halted while the config write is in flight; restart afterwards
      engState_reg     <= ENG_IDLE;
      avgCnt_reg       <= 11'h000;
      acc_reg          <= 24'sh000000;
      startPending_reg <= 1'b1;
    end
    else
    begin
      case (engState_reg)
        ENG_IDLE:
        begin
          if (startPending_reg)
          begin
            startPending_reg <= 1'b0;
            if (anyStep)
            begin
              engState_reg <= ENG_CONV;
              step_reg     <= firstStep;
              timer_reg    <= loadTime(firstStep, cfg_reg);
            end
          end
        end
        ENG_CONV:
        begin
          if (timer_reg > 18'h00001)
            timer_reg <= timer_reg - 18'h00001;
          else if (hasNext)
          begin
            acc_reg   <= accSum;
            step_reg  <= nextStep;
            timer_reg <= loadTime(nextStep, cfg_reg);
          end
          else
          begin
            step_reg  <= firstStep;
            timer_reg <= loadTime(firstStep, cfg_reg);
            if (avgCnt_reg + 11'h001 == avgTarget)
            begin
              avgCnt_reg <= 11'h000;
              acc_reg    <= 24'sh000000;
              if (stepEnabled[0])
                result_reg <= {avgValue[SAMPLE_WIDTH-1:0], {RESULT_LSB{1'b0}}};
              if (!cfg_reg.operating_mode_select[2])
                engState_reg <= ENG_IDLE;
            end
            else
            begin
              avgCnt_reg <= avgCnt_reg + 11'h001;
              acc_reg    <= accSum;
            end
          end
        end
        default:
          engState_reg <= ENG_IDLE;
      endcase
    end
  end

  // line is open drain: only ever pulled low
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sdaOut     <= 1'b0;
      sdaOe      <= 1'b0;
      convActive <= 1'b0;
      muxChannel <= 2'h0;
      muxBus     <= 1'b0;
    end
    else
    begin
      sdaOut     <= 1'b0;
      sdaOe      <= sdaOe_reg;
      convActive <= (engState_reg == ENG_CONV);
      muxChannel <= 2'(step_reg >> 1);
      muxBus     <= step_reg[0];
    end
  end

endmodule
`default_nettype wire

// >>> verification/shunt_monitor_properties.sv
// port-level checks for the shunt monitor
`timescale 1ns/100ps
`default_nettype none
module shunt_monitor_properties
#(
  parameter int unsigned CONV_CYCLES [8] = monitor_pkg::CONV_CYCLES_DEF
)
(
  // clock and reset
  input wire logic                                         core_clk,
  input wire logic                                         rstn,
  // two-wire link
  input wire logic                                         scl,
  input wire logic                                         sdaIn,
  input wire logic                                         sdaOut,
  input wire logic                                         sdaOe,
  // converter front end
  input wire logic signed [monitor_pkg::SAMPLE_WIDTH-1:0] shuntSample,
  input wire logic                                         convActive,
  input wire logic [1:0]                                   muxChannel,
  input wire logic                                         muxBus
);
  import monitor_pkg::*;
  function automatic int unsigned shortest();
    shortest = CONV_CYCLES[0];
    foreach (CONV_CYCLES[i])
      if (CONV_CYCLES[i] < shortest)
        shortest = CONV_CYCLES[i];
  endfunction
  localparam int unsigned MIN_STEP = shortest();
  int unsigned stepCnt;
  // slack of two: stepCnt restarts a cycle after the mux changes, so it ends one below the step length
  always_ff @(posedge core_clk)
    if (!rstn || !convActive || $changed({muxChannel, muxBus}))
      stepCnt <= 0;
    else
      stepCnt <= stepCnt + 1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_ack_held;
    sdaOe [*8];
  endsequence
  sequence s_first_step;
    convActive && muxChannel == 2'h0 && !muxBus;
  endsequence
  a_open_drain: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !convActive && !sdaOe && muxChannel == 2'h0 && !muxBus)
    else $error("outputs active in reset");
  a_run_after_reset: assert property ($rose(rstn) |-> ##[1:2] s_first_step)
    else $error("conversion not started after reset");
  a_mux_legal: assert property (convActive |-> muxChannel != 2'h3)
    else $error("no such channel");
  a_step_length: assert property (convActive && $past(convActive) && $changed({muxChannel, muxBus}) |-> stepCnt + 2 >= MIN_STEP)
    else $error("step too short");
  a_oe_scl_low: assert property ($changed(sdaOe) |-> !scl)
    else $error("data changed with clock high");
  a_ack_hold: assert property ($rose(sdaOe) |-> s_ack_held)
    else $error("data bit not held");
  a_bus_follows: assert property (convActive && $past(convActive) && $rose(muxBus) |-> $stable(muxChannel))
    else $error("bus phase on other channel");
endmodule
bind shunt_monitor shunt_monitor_properties #(.CONV_CYCLES(CONV_CYCLES)) shunt_monitor_properties_i (
  .core_clk(core_clk), .rstn(rstn), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .shuntSample(shuntSample), .convActive(convActive), .muxChannel(muxChannel), .muxBus(muxBus));
`default_nettype wire

// >>> verification/i2c_host_model.sv
// two-wire host reading and writing 16-bit registers
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
(
  // clock
  input  wire logic        core_clk,
  // link, a released line floats to the pull-up
  output var  logic        scl,
  output var  logic        sdaLow,
  input  wire logic        sdaLine,
  // finished reads
  output var  logic        rdValid,
  output var  logic [15:0] rdData
);
  import monitor_pkg::*;
  localparam int HALF = 10;
  initial
  begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdValid = 1'b0;
    rdData = 16'h0000;
  end
  // data moves two cycles after the clock falls, so no false start or stop
  task automatic edge_wait(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic bit_out(input logic b);
    edge_wait(2);
    sdaLow = !b;
    edge_wait(HALF);
    scl = 1'b1;
    edge_wait(HALF);
    scl = 1'b0;
  endtask
  task automatic bit_in(output logic b);
    edge_wait(2);
    sdaLow = 1'b0;
    edge_wait(HALF);
    scl = 1'b1;
    edge_wait(HALF);
    b = sdaLine;
    scl = 1'b0;
  endtask
  task automatic start();
    edge_wait(2);
    sdaLow = 1'b0;
    edge_wait(HALF);
    scl = 1'b1;
    edge_wait(HALF);
    sdaLow = 1'b1;
    edge_wait(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    edge_wait(2);
    sdaLow = 1'b1;
    edge_wait(HALF);
    scl = 1'b1;
    edge_wait(HALF);
    sdaLow = 1'b0;
    edge_wait(HALF);
  endtask
  task automatic byte_out(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--)
      bit_out(b[i]);
    bit_in(nack);
  endtask
  task automatic byte_in(output logic [7:0] b, input logic last);
    for (int i = 7; i >= 0; i--)
      bit_in(b[i]);
    bit_out(last);
  endtask
  task automatic write_word(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] d, output logic nack);
    logic [3:0] n;
    start();
    byte_out({dev, 1'b0}, n[0]);
    byte_out(ptr, n[1]);
    byte_out(d[15:8], n[2]);
    byte_out(d[7:0], n[3]);
    stop();
    nack = |n;
  endtask
  task automatic read_word(input logic [6:0] dev, input logic [7:0] ptr, output logic nack);
    logic [2:0]  n;
    logic [15:0] d;
    start();
    byte_out({dev, 1'b0}, n[0]);
    byte_out(ptr, n[1]);
    start();
    byte_out({dev, 1'b1}, n[2]);
    byte_in(d[15:8], 1'b0);
    byte_in(d[7:0], 1'b1);
    stop();
    nack = |n;
    rdData = d;
    rdValid = 1'b1;
    edge_wait(1);
    rdValid = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_shunt_monitor.sv
// self-checking bench for the shunt monitor
`timescale 1ns/100ps
`default_nettype none
module test_shunt_monitor;
  import monitor_pkg::*;
  localparam int unsigned STEPS [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
  logic                           coreClk = 1'b0;
  logic                           rstn = 1'b0;
  logic                           scl;
  logic                           hostLow;
  logic                           sdaOut;
  logic                           sdaOe;
  logic signed [SAMPLE_WIDTH-1:0] shuntSample = '0;
  logic                           convActive;
  logic [1:0]                     muxChannel;
  logic                           muxBus;
  logic                           rdValid;
  logic [15:0]                    rdData;
  logic signed [SAMPLE_WIDTH-1:0] pat [4] = '{default: '0};
  logic [15:0]                    expQ [$];
  logic                           inStep = 1'b0;
  logic                           nk;
  int                             idx = 0;
  int                             sum;
  int                             seed;
  int                             nFail = 0;
  int                             checked = 0;
  wire logic sdaLine = !(hostLow || (sdaOe && !sdaOut));
  shunt_monitor #(.DEV_ADDR(DEV_ADDR_DEF), .CONV_CYCLES(STEPS)) shunt_monitor_i (
    .core_clk(coreClk), .rstn(rstn), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .shuntSample(shuntSample), .convActive(convActive), .muxChannel(muxChannel), .muxBus(muxBus));
  i2c_host_model i2c_host_model_i (.core_clk(coreClk), .scl(scl), .sdaLow(hostLow), .sdaLine(sdaLine),
    .rdValid(rdValid), .rdData(rdData));
  initial
    forever #20 coreClk = ~coreClk;
  // front end cycles a four-sample pattern counted from each restart
  always @(negedge coreClk)
  begin
    if (convActive !== 1'b1)
      idx = 0;
    else if (inStep && !(muxChannel === 2'h0 && muxBus === 1'b0))
      idx = idx + 1;
    inStep = convActive === 1'b1 && muxChannel === 2'h0 && muxBus === 1'b0;
    shuntSample <= pat[idx % 4];
  end
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      nFail++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    chk16({15'h0000, e}, {15'h0000, g});
  endtask
  always @(posedge coreClk)
    if (rdValid === 1'b1)
      chk16(expQ.size() > 0 ? expQ.pop_front() : 16'hXXXX, rdData);
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
    i2c_host_model_i.write_word(DEV_ADDR_DEF, ptr, d, nk);
    chk1(1'b0, nk);
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [15:0] e);
    expQ.push_back(e);
    i2c_host_model_i.read_word(DEV_ADDR_DEF, ptr, nk);
    chk1(1'b0, nk);
  endtask
  // n above zero waits for n ch1 shunt steps, zero waits for idle
  task automatic await(input int n);
    int k;
    for (k = 0; k < 20000 && (n > 0 ? idx < n : convActive !== 1'b0); k++)
      @(negedge coreClk);
    if (k == 20000)
    begin
      nFail++;
      test_done();
    end
  endtask
  function automatic logic [15:0] expw(input int s);
    expw = {s[12:0], 3'b000};
  endfunction
  task automatic test_done();
    $display("compares %0d, mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    seed = $urandom(86);
    repeat (5) @(negedge coreClk);
    rstn = 1'b1;
    repeat (4) @(negedge coreClk);
    rd(CFG_OFFSET, CFG_RESET);
    rd(RESULT_OFFSET, RESULT_RESET);
    $display("test reset done");
    for (int k = 0; k < 8; k++)
    begin
      wr(CFG_OFFSET, {1'b0, 3'(k), 3'(k), 3'(k), 3'(k), 3'(k)});
      // codes 000 and 100 are power-down, so nothing may run
      if (k % 4 == 0)
        chk1(1'b0, convActive);
      rd(CFG_OFFSET, {1'b0, 3'(k), 3'(k), 3'(k), 3'(k), 3'(k)});
    end
    $display("test fields done");
    pat = '{4{13'sh0FFF}};
    wr(CFG_OFFSET, 16'h7007);
    await(2);
    rd(RESULT_OFFSET, 16'h7FF8);
    pat = '{4{13'sh1830}};
    await(idx + 2);
    rd(RESULT_OFFSET, 16'hC180);
    $display("test scale done");
    foreach (pat[i])
      pat[i] = 13'($urandom);
    sum = pat[0] + pat[1] + pat[2] + pat[3];
    wr(CFG_OFFSET, 16'h7207);
    await(5);
    rd(RESULT_OFFSET, expw(sum >>> 2));
    wr(CFG_OFFSET, 16'h7607);
    await(65);
    rd(RESULT_OFFSET, expw(sum >>> 2));
    $display("test average done");
    pat[0] = 13'($urandom);
    pat = '{4{pat[0]}};
    sum = pat[0];
    wr(CFG_OFFSET, 16'h7001);
    await(1);
    await(0);
    pat = '{4{~pat[0]}};
    // a config read must not start another shot with the new pattern
    rd(CFG_OFFSET, 16'h7001);
    rd(RESULT_OFFSET, expw(sum));
    chk1(1'b0, convActive);
    $display("test single done");
    wr(CFG_OFFSET, 16'h8000);
    rd(CFG_OFFSET, CFG_RESET);
    rd(8'h02, 16'h0000);
    wr(8'h05, 16'h1234);
    i2c_host_model_i.write_word(DEV_ADDR_DEF ^ 7'h01, CFG_OFFSET, 16'h0000, nk);
    chk1(1'b1, nk);
    rd(CFG_OFFSET, CFG_RESET);
    $display("test refusals done");
    test_done();
  end
endmodule
`default_nettype wire
